/* io_board_consts.vh */
// Constants for the internal I/O board control block
// Overview of operation
// - Configuration words go out serially on one shared clock and data pair.
// - All targets are configured after power-up and on channel or level change.
// - Attenuator load strobe makes the step attenuator capture shifted bits.
// - Synthesizer load strobe makes the increment synthesizer capture the word.
// - First oscillator strobe loads the word into the 10.8215 MHz oscillator.
// - Second oscillator strobe loads the word into the 81.7 MHz oscillator.
// - Keypad inputs are debounced, then the keypad interrupt is raised if any key line is active.
// - Three analog inputs are digitised for the host to read.
// - Display uses 256k by 16 frame memory with controller and drive control.
// - Display drive voltage is never enabled without active display logic signals.
// - Drive voltage is on only while the row latch pulse toggles.
// - Printer port raises its own interrupt when printer signals are present.
// - A host-written 12-bit code drives the transmit level converter.
// - A host-written 8-bit code drives the reference tuning converter.
`ifndef IO_BOARD_CONSTS_VH
`define IO_BOARD_CONSTS_VH
`define SER_WORD_BITS 24
`define SER_CLK_DIV 8
`define TGT_ATTEN 2'h0
`define TGT_SYNTH 2'h1
`define TGT_FINE_OSC 2'h2
`define TGT_SECOND_LO 2'h3
`define KEY_LINES 8
`define KEY_SAMPLE_DIV 1000
`define KEY_STABLE_SAMPLES 16
`define LP_TIMEOUT_NS 100000
`define CLK_PERIOD_NS 4
`define LP_TIMEOUT_CYC (`LP_TIMEOUT_NS / `CLK_PERIOD_NS)
`define FIFO_DEPTH 8
`define TXLVL_BITS 12
`define REFTUNE_BITS 8
`define ADC_BITS 10
`define ADC_CHANNELS 3
`define FRAME_ADDR_BITS 18
`define FRAME_DATA_BITS 16
`endif

/* cfg_fifo.v */
// Small synchronous FIFO for serial configuration requests
`timescale 1ns/1ps
`default_nettype none
module cfg_fifo #(
    parameter WIDTH = 26,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_sys,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];
    always @(posedge clk_sys) begin
        if (in_valid && !full)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full)
                wr_ptr <= wr_ptr + 1'b1;
            if (out_ready && !empty)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule // cfg_fifo
`default_nettype wire

/* io_board_ctrl.v */
// Board I/O control: serial configuration, keypad, ADC, display gating, printer irq, DACs
`timescale 1ns/1ps
`default_nettype none
`include "io_board_consts.vh"
module io_board_ctrl #(
    parameter WORD_BITS = `SER_WORD_BITS,
    parameter CLK_DIV = `SER_CLK_DIV,
    parameter KEY_LINES = `KEY_LINES,
    parameter KEY_SAMPLE_DIV = `KEY_SAMPLE_DIV,
    parameter KEY_STABLE = `KEY_STABLE_SAMPLES,
    parameter LP_TIMEOUT = `LP_TIMEOUT_CYC,
    parameter ADC_BITS = `ADC_BITS
) (
    input wire clk_sys,
    input wire reset_n,
    input wire cfg_valid,
    output wire cfg_ready,
    input wire [1:0] cfg_target,
    input wire [WORD_BITS-1:0] cfg_word,
    input wire cfg_refresh,
    input wire [WORD_BITS-1:0] init_atten_word,
    input wire [WORD_BITS-1:0] init_synth_word,
    input wire [WORD_BITS-1:0] init_fine_word,
    input wire [WORD_BITS-1:0] init_second_word,
    output reg cfg_busy,
    output reg ser_clock,
    output reg ser_data,
    output reg attenuator_load_strobe,
    output reg synth_load_strobe,
    output reg fine_osc_load_strobe,
    output reg second_lo_load_strobe,
    input wire [KEY_LINES-1:0] key_rows,
    input wire [KEY_LINES-1:0] key_cols,
    output reg [KEY_LINES-1:0] key_row_data,
    output reg [KEY_LINES-1:0] key_col_data,
    output reg keypad_irq_line,
    input wire keypad_irq_ack,
    input wire [1:0] adc_select,
    input wire adc_start,
    input wire [ADC_BITS-1:0] adc_sample,
    output reg [1:0] adc_mux,
    output reg [ADC_BITS-1:0] adc_rssi,
    output reg [ADC_BITS-1:0] adc_temperature,
    output reg [ADC_BITS-1:0] adc_aux,
    output reg adc_done,
    input wire display_logic_on,
    input wire row_latch_pulse,
    output reg display_drive_enable,
    input wire printer_signals_present,
    output reg printer_irq_line,
    input wire tx_level_write,
    input wire [`TXLVL_BITS-1:0] tx_level_in,
    output reg [`TXLVL_BITS-1:0] tx_level_code,
    input wire ref_tune_write,
    input wire [`REFTUNE_BITS-1:0] ref_tune_in,
    output reg [`REFTUNE_BITS-1:0] ref_tune_code
);
    reg rst_meta, rst_n;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Power-up sequencer feeds the four initial words through the same FIFO
    reg [2:0] init_idx;
    reg init_active;
    reg [1:0] init_tgt;
    reg [WORD_BITS-1:0] init_word;
    always @* begin
        init_tgt = init_idx[1:0];
        case (init_idx[1:0])
            `TGT_ATTEN: init_word = init_atten_word;
            `TGT_SYNTH: init_word = init_synth_word;
            `TGT_FINE_OSC: init_word = init_fine_word;
            default: init_word = init_second_word;
        endcase
    end
    wire fifo_in_ready;
    wire fifo_in_valid = init_active ? 1'b1 : cfg_valid;
    wire [WORD_BITS+1:0] fifo_in_data = init_active ? {init_tgt, init_word} : {cfg_target, cfg_word};
    assign cfg_ready = fifo_in_ready && !init_active;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            init_active <= 1'b1;
            init_idx <= 3'h0;
        end else if (init_active) begin
            if (fifo_in_ready) begin
                init_idx <= init_idx + 3'h1;
                if (init_idx == 3'h3)
                    init_active <= 1'b0;
            end
        end else if (cfg_refresh) begin
            init_active <= 1'b1;
            init_idx <= 3'h0;
        end
    end

    wire fifo_out_valid;
    reg fifo_out_ready;
    wire [WORD_BITS+1:0] fifo_out_data;
    cfg_fifo #(.WIDTH(WORD_BITS+2), .DEPTH(`FIFO_DEPTH), .AW(3)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Serial shifter; data changes on falling clock, targets sample on rising
    localparam S_IDLE = 2'h0;
    localparam S_SHIFT = 2'h1;
    localparam S_LOAD = 2'h2;
    localparam S_GAP = 2'h3;
    reg [1:0] state;
    reg [WORD_BITS-1:0] shreg;
    reg [1:0] cur_tgt;
    reg [7:0] bit_cnt;
    reg [7:0] div_cnt;
    wire tick = (div_cnt == CLK_DIV[7:0] - 8'h1);
    always @* begin
        fifo_out_ready = (state == S_IDLE);
    end
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            shreg <= {WORD_BITS{1'b0}};
            cur_tgt <= 2'h0;
            bit_cnt <= 8'h00;
            div_cnt <= 8'h00;
            cfg_busy <= 1'b0;
            ser_clock <= 1'b0;
            ser_data <= 1'b0;
            attenuator_load_strobe <= 1'b0;
            synth_load_strobe <= 1'b0;
            fine_osc_load_strobe <= 1'b0;
            second_lo_load_strobe <= 1'b0;
        end else begin
            div_cnt <= (state == S_IDLE || tick) ? 8'h00 : div_cnt + 8'h01;
            case (state)
                S_IDLE: begin
                    cfg_busy <= 1'b0;
                    if (fifo_out_valid) begin
                        cur_tgt <= fifo_out_data[WORD_BITS+1:WORD_BITS];
                        shreg <= fifo_out_data[WORD_BITS-1:0];
                        ser_data <= fifo_out_data[WORD_BITS-1];
                        bit_cnt <= 8'h00;
                        cfg_busy <= 1'b1;
                        state <= S_SHIFT;
                    end
                end
                S_SHIFT: if (tick) begin
                    ser_clock <= !ser_clock;
                    if (ser_clock) begin
                        if (bit_cnt == WORD_BITS[7:0] - 8'h1) begin
                            state <= S_LOAD;
                        end else begin
                            bit_cnt <= bit_cnt + 8'h01;
                            shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                            ser_data <= shreg[WORD_BITS-2];
                        end
                    end
                end
                S_LOAD: if (tick) begin
                    attenuator_load_strobe <= (cur_tgt == `TGT_ATTEN);
                    synth_load_strobe <= (cur_tgt == `TGT_SYNTH);
                    fine_osc_load_strobe <= (cur_tgt == `TGT_FINE_OSC);
                    second_lo_load_strobe <= (cur_tgt == `TGT_SECOND_LO);
                    state <= S_GAP;
                end
                S_GAP: if (tick) begin
                    attenuator_load_strobe <= 1'b0;
                    synth_load_strobe <= 1'b0;
                    fine_osc_load_strobe <= 1'b0;
                    second_lo_load_strobe <= 1'b0;
                    ser_data <= 1'b0;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Keypad: synchronise every line, then debounce on slow sample enable
    reg [2*KEY_LINES-1:0] key_meta, key_sync, key_cand;
    reg [15:0] key_div;
    reg [7:0] stable_cnt;
    wire key_tick = (key_div == KEY_SAMPLE_DIV[15:0] - 16'h1);
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            key_meta <= {2*KEY_LINES{1'b0}};
            key_sync <= {2*KEY_LINES{1'b0}};
            key_cand <= {2*KEY_LINES{1'b0}};
            key_div <= 16'h0000;
            stable_cnt <= 8'h00;
            key_row_data <= {KEY_LINES{1'b0}};
            key_col_data <= {KEY_LINES{1'b0}};
            keypad_irq_line <= 1'b0;
        end else begin
            key_meta <= {key_rows, key_cols};
            key_sync <= key_meta;
            key_div <= key_tick ? 16'h0000 : key_div + 16'h0001;
            if (key_tick) begin
                if (key_sync != key_cand) begin
                    key_cand <= key_sync;
                    stable_cnt <= 8'h00;
                end else if (stable_cnt < KEY_STABLE[7:0]) begin
                    stable_cnt <= stable_cnt + 8'h01;
                end
            end
            if (key_tick && key_sync == key_cand && stable_cnt == KEY_STABLE[7:0] - 8'h1) begin
                key_row_data <= key_cand[2*KEY_LINES-1:KEY_LINES];
                key_col_data <= key_cand[KEY_LINES-1:0];
                if (|key_cand)
                    keypad_irq_line <= 1'b1;
            end else if (keypad_irq_ack) begin
                keypad_irq_line <= 1'b0;
            end
        end
    end

    reg adc_busy;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            adc_mux <= 2'h0;
            adc_busy <= 1'b0;
            adc_done <= 1'b0;
            adc_rssi <= {ADC_BITS{1'b0}};
            adc_temperature <= {ADC_BITS{1'b0}};
            adc_aux <= {ADC_BITS{1'b0}};
        end else begin
            adc_done <= 1'b0;
            if (adc_start && !adc_busy) begin
                adc_mux <= adc_select;
                adc_busy <= 1'b1;
            end else if (adc_busy) begin
                adc_busy <= 1'b0;
                adc_done <= 1'b1;
                case (adc_mux)
                    2'h0: adc_rssi <= adc_sample;
                    2'h1: adc_temperature <= adc_sample;
                    default: adc_aux <= adc_sample;
                endcase
            end
        end
    end

    // Display drive gating; frame memory itself sits outside this block
    reg [2:0] lp_sync;
    reg [1:0] logic_sync;
    reg [23:0] lp_idle;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lp_sync <= 3'h0;
            logic_sync <= 2'h0;
            // Start as if stopped: drive waits for a real pulse edge
            lp_idle <= LP_TIMEOUT[23:0];
            display_drive_enable <= 1'b0;
        end else begin
            lp_sync <= {lp_sync[1:0], row_latch_pulse};
            logic_sync <= {logic_sync[0], display_logic_on};
            if (lp_sync[2] != lp_sync[1])
                lp_idle <= 24'h00_0000;
            else if (lp_idle != LP_TIMEOUT[23:0])
                lp_idle <= lp_idle + 24'h00_0001;
            display_drive_enable <= logic_sync[1] && (lp_idle != LP_TIMEOUT[23:0]);
        end
    end

    reg [1:0] prn_sync;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prn_sync <= 2'h0;
            printer_irq_line <= 1'b0;
            tx_level_code <= 12'h000;
            ref_tune_code <= 8'h00;
        end else begin
            prn_sync <= {prn_sync[0], printer_signals_present};
            printer_irq_line <= prn_sync[1];
            if (tx_level_write)
                tx_level_code <= tx_level_in;
            if (ref_tune_write)
                ref_tune_code <= ref_tune_in;
        end
    end
endmodule // io_board_ctrl
`default_nettype wire

/* io_board_ctrl_props.sv */
// Concurrent checks on the board I/O control top ports
`timescale 1ns/1ps
`default_nettype none
module io_board_ctrl_props #(
    parameter CLK_DIV = 2,
    parameter LP_TIMEOUT = 50
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic cfg_busy,
    input wire logic ser_clock,
    input wire logic ser_data,
    input wire logic attenuator_load_strobe,
    input wire logic synth_load_strobe,
    input wire logic fine_osc_load_strobe,
    input wire logic second_lo_load_strobe,
    input wire logic [7:0] key_row_data,
    input wire logic [7:0] key_col_data,
    input wire logic keypad_irq_line,
    input wire logic display_logic_on,
    input wire logic row_latch_pulse,
    input wire logic display_drive_enable,
    input wire logic printer_signals_present,
    input wire logic printer_irq_line,
    input wire logic tx_level_write,
    input wire logic [11:0] tx_level_in,
    input wire logic [11:0] tx_level_code,
    input wire logic ref_tune_write,
    input wire logic [7:0] ref_tune_in,
    input wire logic [7:0] ref_tune_code
);
    wire logic [3:0] strobes = {second_lo_load_strobe, fine_osc_load_strobe, synth_load_strobe,
        attenuator_load_strobe};
    logic [3:0] strobe_len;
    logic [15:0] lp_idle;
    logic lp_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Raw edge seen here; the design sees it a few cycles later
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            strobe_len <= 4'h0;
            lp_idle <= 16'h0000;
            lp_q <= 1'b0;
        end else begin
            strobe_len <= (|strobes) ? strobe_len + 4'h1 : 4'h0;
            lp_q <= row_latch_pulse;
            lp_idle <= (lp_q != row_latch_pulse) ? 16'h0000 : lp_idle + 16'h0001;
        end
    end
    AST_ONE_TARGET: assert property ($onehot0(strobes))
        else $error("two load strobes high together");
    AST_STROBE_AFTER_SHIFT: assert property ($rose(|strobes) |-> !ser_clock && !$past(ser_clock))
        else $error("load strobe rose with serial clock active");
    AST_STROBE_WIDTH: assert property ($fell(|strobes) |-> strobe_len == CLK_DIV)
        else $error("load strobe width wrong");
    AST_SHIFT_BUSY: assert property (ser_clock |-> cfg_busy)
        else $error("serial clock high while not busy");
    AST_DATA_HELD: assert property (ser_clock && $past(ser_clock) |-> $stable(ser_data))
        else $error("serial data moved while clock high");
    AST_KEY_IRQ_DATA: assert property ($rose(keypad_irq_line) |-> (key_row_data | key_col_data) != 8'h00)
        else $error("keypad irq with empty key data");
    AST_DRIVE_LOGIC: assert property (!display_logic_on [*4] |-> !display_drive_enable)
        else $error("drive enabled without display logic");
    AST_DRIVE_LP: assert property (lp_idle > LP_TIMEOUT + 8 |-> !display_drive_enable)
        else $error("drive enabled with stopped row latch pulse");
    AST_PRN_IRQ: assert property (printer_irq_line == $past(printer_signals_present, 3))
        else $error("printer irq does not follow signals");
    AST_TXLVL: assert property (tx_level_write |=> tx_level_code == $past(tx_level_in))
        else $error("transmit level code not loaded");
    AST_REFTUNE: assert property (ref_tune_write |=> ref_tune_code == $past(ref_tune_in))
        else $error("reference tune code not loaded");
endmodule // io_board_ctrl_props
bind io_board_ctrl io_board_ctrl_props #(.CLK_DIV(CLK_DIV), .LP_TIMEOUT(LP_TIMEOUT)) u_props (
    .clk_sys(clk_sys), .reset_n(reset_n), .cfg_busy(cfg_busy), .ser_clock(ser_clock), .ser_data(ser_data),
    .attenuator_load_strobe(attenuator_load_strobe), .synth_load_strobe(synth_load_strobe),
    .fine_osc_load_strobe(fine_osc_load_strobe), .second_lo_load_strobe(second_lo_load_strobe),
    .key_row_data(key_row_data), .key_col_data(key_col_data), .keypad_irq_line(keypad_irq_line),
    .display_logic_on(display_logic_on), .row_latch_pulse(row_latch_pulse),
    .display_drive_enable(display_drive_enable), .printer_signals_present(printer_signals_present),
    .printer_irq_line(printer_irq_line), .tx_level_write(tx_level_write), .tx_level_in(tx_level_in),
    .tx_level_code(tx_level_code), .ref_tune_write(ref_tune_write), .ref_tune_in(ref_tune_in),
    .ref_tune_code(ref_tune_code));
`default_nettype wire

/* serial_targets.sv */
// Behavioural serial targets: shift on clock rise, capture on load strobe
`timescale 1ns/1ps
`default_nettype none
module serial_targets (
    input wire logic ser_clock,
    input wire logic ser_data,
    input wire logic [3:0] strobes,
    output logic [23:0] last_word,
    output logic [1:0] last_tgt,
    output logic [7:0] bits_seen,
    output int loads
);
    logic [23:0] sh = 24'h00_0000;
    logic [7:0] nbits = 8'h00;
    logic [7:0] base = 8'h00;
    wire logic any_strobe = |strobes;
    initial loads = 0;
    always @(posedge ser_clock) begin
        sh <= {sh[22:0], ser_data};
        nbits <= nbits + 8'h01;
    end
    always @(posedge any_strobe) begin
        last_word <= sh;
        last_tgt <= {strobes[3] | strobes[2], strobes[3] | strobes[1]};
        bits_seen <= nbits - base;
        base <= nbits;
        loads <= loads + 1;
    end
endmodule // serial_targets
`default_nettype wire

/* io_board_ctrl_bench.sv */
// Self-checking bench for the board I/O control block
`timescale 1ns/1ps
`default_nettype none
module io_board_ctrl_bench;
    logic clk_sys = 1'b0, reset_n = 1'b0, cfg_valid = 1'b0, cfg_refresh = 1'b0, keypad_irq_ack = 1'b0;
    logic adc_start = 1'b0, display_logic_on = 1'b0, row_latch_pulse = 1'b0, lp_run = 1'b0;
    logic printer_signals_present = 1'b0, tx_level_write = 1'b0, ref_tune_write = 1'b0;
    logic [1:0] cfg_target = 2'h0, adc_select = 2'h0;
    logic [23:0] cfg_word = 24'h00_0000;
    logic [23:0] iw [4] = '{24'hA5_0F3C, 24'h80_0001, 24'h12_3456, 24'hFF_FFFE};
    logic [7:0] key_rows = 8'h00, key_cols = 8'h00, ref_tune_in = 8'h00;
    logic [9:0] adc_sample = 10'h000;
    logic [11:0] tx_level_in = 12'h000;
    wire logic cfg_ready, cfg_busy, ser_clock, ser_data, keypad_irq_line, adc_done, drive_en, printer_irq_line;
    wire logic [3:0] stb;
    wire logic [7:0] krd, kcd, ref_tune_code, bits_seen;
    wire logic [1:0] adc_mux, last_tgt;
    wire logic [9:0] a_rssi, a_temp, a_aux;
    wire logic [11:0] tx_level_code;
    wire logic [23:0] last_word;
    int loads, done_loads = 0, fail_count = 0, checks = 0, cyc = 0;
    io_board_ctrl #(.CLK_DIV(2), .KEY_SAMPLE_DIV(4), .KEY_STABLE(3), .LP_TIMEOUT(50)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
        .cfg_target(cfg_target), .cfg_word(cfg_word), .cfg_refresh(cfg_refresh), .init_atten_word(iw[0]),
        .init_synth_word(iw[1]), .init_fine_word(iw[2]), .init_second_word(iw[3]), .cfg_busy(cfg_busy),
        .ser_clock(ser_clock), .ser_data(ser_data), .attenuator_load_strobe(stb[0]), .synth_load_strobe(stb[1]),
        .fine_osc_load_strobe(stb[2]), .second_lo_load_strobe(stb[3]), .key_rows(key_rows), .key_cols(key_cols),
        .key_row_data(krd), .key_col_data(kcd), .keypad_irq_line(keypad_irq_line), .keypad_irq_ack(keypad_irq_ack),
        .adc_select(adc_select), .adc_start(adc_start), .adc_sample(adc_sample), .adc_mux(adc_mux),
        .adc_rssi(a_rssi), .adc_temperature(a_temp), .adc_aux(a_aux), .adc_done(adc_done),
        .display_logic_on(display_logic_on), .row_latch_pulse(row_latch_pulse), .display_drive_enable(drive_en),
        .printer_signals_present(printer_signals_present), .printer_irq_line(printer_irq_line),
        .tx_level_write(tx_level_write), .tx_level_in(tx_level_in), .tx_level_code(tx_level_code),
        .ref_tune_write(ref_tune_write), .ref_tune_in(ref_tune_in), .ref_tune_code(ref_tune_code));
    serial_targets targets (.ser_clock(ser_clock), .ser_data(ser_data), .strobes(stb), .last_word(last_word),
        .last_tgt(last_tgt), .bits_seen(bits_seen), .loads(loads));
    initial forever #2 clk_sys = ~clk_sys;
    // Link-rate pulse, toggled every 24 ns, always on a falling system clock edge
    initial forever begin
        #24;
        if (lp_run) row_latch_pulse = ~row_latch_pulse;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Watchdog bounds this wait
    task automatic wait_load(input logic [1:0] t, input logic [23:0] w);
        while (loads <= done_loads) tick(1);
        done_loads++;
        check("target", last_tgt, t);
        check("word", last_word, w);
        check("bits", bits_seen, 24);
    endtask
    task automatic t_init;
        for (int i = 0; i < 4; i++) wait_load(i[1:0], iw[i]);
    endtask
    // Offer ten words, which the full queue refuses at least once, then drain them
    task automatic t_fill;
        int acc;
        logic refused;
        acc = 0;
        refused = 1'b0;
        cfg_valid <= 1'b1;
        cfg_word <= 24'h3C_C300;
        while (acc < 10) begin
            tick(1);
            if (cfg_ready === 1'b1) begin
                acc++;
                cfg_target <= acc[1:0];
                cfg_word <= 24'h3C_C300 ^ (acc * 24'h05_0A0B);
            end else refused = 1'b1;
        end
        cfg_valid <= 1'b0;
        check("refused", refused, 1);
        for (int i = 0; i < 10; i++) wait_load(i[1:0], 24'h3C_C300 ^ (i * 24'h05_0A0B));
    endtask
    task automatic t_refresh;
        iw[0] <= 24'h00_0001;
        iw[2] <= 24'h7F_FF00;
        cfg_refresh <= 1'b1;
        tick(1);
        cfg_refresh <= 1'b0;
        t_init();
    endtask
    task automatic t_keys;
        key_rows <= 8'h04;
        key_cols <= 8'h10;
        tick(8);
        key_rows <= 8'h00;
        key_cols <= 8'h00;
        tick(40);
        check("bounce irq", keypad_irq_line, 0);
        key_rows <= 8'h80;
        key_cols <= 8'h01;
        tick(40);
        check("key irq", keypad_irq_line, 1);
        check("rows", krd, 8'h80);
        check("cols", kcd, 8'h01);
        keypad_irq_ack <= 1'b1;
        tick(1);
        keypad_irq_ack <= 1'b0;
        tick(2);
        check("acked irq", keypad_irq_line, 0);
        key_rows <= 8'h00;
        key_cols <= 8'h00;
        tick(40);
        check("release rows", krd, 8'h00);
        check("release irq", keypad_irq_line, 0);
    endtask
    task automatic t_adc;
        for (int s = 0; s < 4; s++) begin
            adc_select <= s[1:0];
            adc_sample <= 10'h2A5 ^ s[9:0];
            adc_start <= 1'b1;
            tick(1);
            adc_start <= 1'b0;
            tick(2);
            check("adc done", adc_done, 1);
            tick(3);
            check("adc done low", adc_done, 0);
            check("adc mux", adc_mux, s);
            check("adc value", {a_aux, a_temp, a_rssi} >> ((s > 2 ? 2 : s) * 10) & 10'h3FF, 10'h2A5 ^ s);
        end
    endtask
    task automatic t_display;
        lp_run = 1'b1;
        tick(40);
        check("drive off no logic", drive_en, 0);
        display_logic_on <= 1'b1;
        tick(40);
        check("drive on", drive_en, 1);
        lp_run = 1'b0;
        tick(70);
        check("drive lp stopped", drive_en, 0);
        lp_run = 1'b1;
        tick(40);
        display_logic_on <= 1'b0;
        tick(6);
        check("drive logic off", drive_en, 0);
    endtask
    task automatic t_misc;
        printer_signals_present <= 1'b1;
        tx_level_write <= 1'b1;
        tx_level_in <= 12'hFFF;
        ref_tune_write <= 1'b1;
        ref_tune_in <= 8'h81;
        tick(1);
        tx_level_write <= 1'b0;
        ref_tune_write <= 1'b0;
        tick(5);
        check("tx level", tx_level_code, 12'hFFF);
        check("ref tune", ref_tune_code, 8'h81);
        check("printer irq", printer_irq_line, 1);
        printer_signals_present <= 1'b0;
        tick(6);
        check("printer irq clear", printer_irq_line, 0);
    endtask
    task automatic wrap_up;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        tick(16);
        reset_n <= 1'b1;
        t_init();
        t_fill();
        t_refresh();
        t_keys();
        t_adc();
        t_display();
        t_misc();
        wrap_up();
    end
endmodule // io_board_ctrl_bench
`default_nettype wire
